// *** design/fut_pkg.sv ***
// package: register map, control fields and timing constants of the flash user test engine
package fut_pkg;
    // ************************************************************
    // register map (byte addresses)
    // ************************************************************
    localparam logic [7:0]  ADDR_CONTROL     = 8'h00;
    localparam logic [7:0]  ADDR_RESULT0     = 8'h04;
    localparam logic [7:0]  ADDR_RESULT4     = 8'h14;
    localparam logic [7:0]  ADDR_SELECT      = 8'h18;
    localparam logic [7:0]  ADDR_LOCK_PRI    = 8'h1c;
    localparam logic [7:0]  ADDR_LOCK_SEC    = 8'h20;
    localparam logic [7:0]  ADDR_MODULE_CFG  = 8'h24;

    // ************************************************************
    // user_test_control fields, plus the read-while-write error bit of the module config register
    // ************************************************************
    localparam int          BIT_UNLOCKED     = 31;
    localparam int          BIT_MARGIN_EN    = 5;
    localparam int          BIT_MARGIN_LVL   = 4;
    localparam int          BIT_SEQ          = 2;
    localparam int          BIT_START        = 1;
    localparam int          BIT_DONE         = 0;
    localparam int          BIT_RWE          = 0;
    localparam logic [31:0] PASSWORD         = 32'hf9f9_9999;
    localparam logic [31:0] CONTROL_RESET    = 32'h0000_0001;

    // ************************************************************
    // signature and scan
    // ************************************************************
    localparam logic [31:0] MISR_POLY        = 32'h04c1_1db7;
    localparam logic [31:0] RESULT_RESET     = 32'h0000_0000;
    localparam logic [2:0]  NUM_PASSES       = 3'h5;
    localparam logic [2:0]  LAST_PASS        = 3'h4;
    localparam int          INTERNAL_EXTRA   = 2;
    localparam int          MARGIN_WAIT_NS   = 80;
    localparam int          CLK_PERIOD_NS    = 10;
    localparam int          MARGIN_WAIT_CYC  = (MARGIN_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

    typedef enum logic [1:0] {
        FUT_IDLE = 2'b00,
        FUT_WAIT = 2'b01,
        FUT_READ = 2'b10,
        FUT_STEP = 2'b11
    } fut_state_t;
endpackage : fut_pkg

// *** design/fut_misr.sv ***
// module: 32-bit multiple input signature register with seed load
`timescale 1ns/1ps
module fut_misr (
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_load,
    input  wire logic [31:0] i_seed,
    input  wire logic        i_shift,
    input  wire logic [31:0] i_data,
    output logic      [31:0] o_sig
);
    typedef struct packed {
        logic [31:0] sig;
    } fut_misr_t;

    fut_misr_t st;
    fut_misr_t next_st;

    always_comb begin
        next_st = st;
        if (i_load) begin
            next_st.sig = i_seed;
        end else if (i_shift) begin
            // one compaction step per array word, never several lanes at once
            next_st.sig = {st.sig[30:0], 1'b0}
                        ^ (st.sig[31] ? fut_pkg::MISR_POLY : 32'h0000_0000)
                        ^ i_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st.sig <= fut_pkg::RESULT_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign o_sig = st.sig;
endmodule : fut_misr

// *** design/fut_engine.sv ***
// module: flash user test engine with AXI4-Lite registers and array scan sequencer
//
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
// Notes on behaviour
// - user read during a running test sets the read-while-write error flag.
// - test and shadow blocks are never scanned; only main blocks exist here.
// - only blocks both selected and unlocked are checked.
// - one 32-bit compacting register; wide pages read repeatedly, one word each.
// - five scans: bits 31:0, 63:32, 95:64, 127:96, then ECC and error flags.
// - data and ECC taken raw; single/double error flags taken after evaluation.
// - locked or absent locations contribute nothing to the signature.
// - software writes to result words seed the signature.
// - password write to control register sets the test-enable bit.
// - sequential bit 1 gives linear order; 0 gives slower internal order.
// - start bit begins check; done set at end; software clears start.
// - clearing start while running terminates; done rises when termination ends.
// - margin armed by margin-enable rising; margin level picks 0s or 1s.
// - margin read leaves locked sectors out of signature and error flags.
// - margin reads add wait states before each array access.
// - control bits: enable 31, margin 5, level 4, sequential 2, start 1, done 0.
// - while done is low, result and mode fields read zero, writes ignored.
module fut_engine #(
    parameter int NBLK     = 8,
    parameter int PAGE_AW  = 4
) (
    input  wire logic                       i_clk,
    input  wire logic                       i_rstn,
    input  wire logic                       i_awvalid,
    output logic                            o_awready,
    input  wire logic [7:0]                 i_awaddr,
    input  wire logic                       i_wvalid,
    output logic                            o_wready,
    input  wire logic [31:0]                i_wdata,
    input  wire logic [3:0]                 i_wstrb,
    output logic                            o_bvalid,
    input  wire logic                       i_bready,
    output logic      [1:0]                 o_bresp,
    input  wire logic                       i_arvalid,
    output logic                            o_arready,
    input  wire logic [7:0]                 i_araddr,
    output logic                            o_rvalid,
    input  wire logic                       i_rready,
    output logic      [31:0]                o_rdata,
    output logic      [1:0]                 o_rresp,
    input  wire logic                       i_user_read,
    output logic                            o_array_req,
    output logic      [$clog2(NBLK)+PAGE_AW-1:0] o_array_addr,
    output logic                            o_array_margin,
    output logic                            o_array_margin_level,
    input  wire logic                       i_array_ack,
    input  wire logic [127:0]               i_array_data,
    input  wire logic [15:0]                i_array_ecc,
    input  wire logic [1:0]                 i_array_single_err,
    input  wire logic [1:0]                 i_array_double_err,
    output logic                            o_test_active
);
    localparam int BW = (NBLK > 1) ? $clog2(NBLK) : 1;

    if (NBLK < 2 || NBLK > 32 || PAGE_AW < 1 || PAGE_AW > 16) begin : g_bad_params
        $error("fut_engine: NBLK must be 2..32 and PAGE_AW 1..16");
    end

    typedef struct packed {
        logic                  unlocked;
        logic                  margin_en;
        logic                  margin_lvl;
        logic                  seq;
        logic                  start;
        logic                  done;
        logic                  margin_armed;
        logic                  op_margin;
        logic [NBLK-1:0]       sel;
        logic [NBLK-1:0]       lock_pri;
        logic [NBLK-1:0]       lock_sec;
        logic                  read_while_write_error;
        logic [4:0][31:0]      result;
        fut_pkg::fut_state_t   state;
        logic [2:0]            pass;
        logic [BW-1:0]         blk;
        logic [PAGE_AW-1:0]    page;
        logic [7:0]            wcnt;
        logic                  array_req;
        logic [BW+PAGE_AW-1:0] array_addr;
        logic                  aw_held;
        logic [7:0]            awaddr;
        logic                  w_held;
        logic [31:0]           wdata;
        logic [3:0]            wstrb;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  rvalid;
        logic [31:0]           rdata;
        logic [1:0]            rresp;
    } fut_state_regs_t;

    fut_state_regs_t st;
    fut_state_regs_t next_st;

    logic               misr_load;
    logic [31:0]        misr_seed;
    logic               misr_shift;
    logic [31:0]        misr_data;
    logic [31:0]        misr_sig;
    logic [PAGE_AW-1:0] page_rev;

    // ************************************************************
    // internal address order: bit-reversed page index
    // ************************************************************
    for (genvar g = 0; g < PAGE_AW; g++) begin : g_rev
        assign page_rev[g] = st.page[PAGE_AW-1-g];
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                m[8*b +: 8] = val[8*b +: 8];
            end
        end
        return m;
    endfunction : merge

    function automatic logic [31:0] ctrl_view(input fut_state_regs_t s);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[fut_pkg::BIT_UNLOCKED] = s.unlocked;
        v[fut_pkg::BIT_START]    = s.start;
        v[fut_pkg::BIT_DONE]     = s.done;
        if (s.done) begin
            v[fut_pkg::BIT_MARGIN_EN]  = s.margin_en;
            v[fut_pkg::BIT_MARGIN_LVL] = s.margin_lvl;
            v[fut_pkg::BIT_SEQ]        = s.seq;
        end
        return v;
    endfunction : ctrl_view

    function automatic logic [7:0] wait_count(input logic seq, input logic margin);
        logic [7:0] c;
        c = seq ? 8'h00 : 8'(fut_pkg::INTERNAL_EXTRA);
        if (margin) begin
            c = c + 8'(fut_pkg::MARGIN_WAIT_CYC);
        end
        return c;
    endfunction : wait_count

    always_comb begin
        logic [31:0] v;
        logic [2:0]  ri;
        logic        eligible;
        logic        last;
        logic        launch;
        v          = 32'h0000_0000;
        ri         = 3'h0;
        eligible   = 1'b0;
        last       = 1'b0;
        launch     = 1'b0;
        next_st    = st;
        misr_load  = 1'b0;
        misr_seed  = st.result[0];
        misr_shift = 1'b0;
        misr_data  = 32'h0000_0000;

        // ************************************************************
        // error flag from user reads
        // ************************************************************
        // ************************************************************
        // AXI4-Lite write channel
        // ************************************************************
        if (i_awvalid && !st.aw_held) begin
            next_st.aw_held = 1'b1;
            next_st.awaddr  = i_awaddr;
        end
        if (i_wvalid && !st.w_held) begin
            next_st.w_held = 1'b1;
            next_st.wdata  = i_wdata;
            next_st.wstrb  = i_wstrb;
        end
        if (st.bvalid && i_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (st.aw_held && st.w_held && !st.bvalid) begin
            next_st.aw_held = 1'b0;
            next_st.w_held  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = fut_pkg::RESP_OKAY;
            if (st.awaddr == fut_pkg::ADDR_CONTROL) begin
                v = merge(ctrl_view(st), st.wdata, st.wstrb);
                if (v == fut_pkg::PASSWORD) begin
                    next_st.unlocked = 1'b1;
                end else if (st.unlocked) begin
                    next_st.unlocked = v[fut_pkg::BIT_UNLOCKED];
                    next_st.start    = v[fut_pkg::BIT_START];
                    if (st.done) begin
                        next_st.margin_en  = v[fut_pkg::BIT_MARGIN_EN];
                        next_st.margin_lvl = v[fut_pkg::BIT_MARGIN_LVL];
                        next_st.seq        = v[fut_pkg::BIT_SEQ];
                        if (v[fut_pkg::BIT_MARGIN_EN] && !st.margin_en) begin
                            next_st.margin_armed = 1'b1;
                        end else if (!v[fut_pkg::BIT_MARGIN_EN]) begin
                            next_st.margin_armed = 1'b0;
                        end
                    end
                    launch = v[fut_pkg::BIT_START] && !st.start && st.done;
                end
            end else if (st.awaddr >= fut_pkg::ADDR_RESULT0
                         && st.awaddr <= fut_pkg::ADDR_RESULT4
                         && st.awaddr[1:0] == 2'b00) begin
                ri = 3'(st.awaddr[4:2] - 3'h1);
                if (st.done) begin
                    next_st.result[ri] = merge(st.result[ri], st.wdata, st.wstrb);
                end
            end else if (st.awaddr == fut_pkg::ADDR_SELECT) begin
                next_st.sel = NBLK'(merge(32'(st.sel), st.wdata, st.wstrb));
            end else if (st.awaddr == fut_pkg::ADDR_LOCK_PRI) begin
                next_st.lock_pri = NBLK'(merge(32'(st.lock_pri), st.wdata, st.wstrb));
            end else if (st.awaddr == fut_pkg::ADDR_LOCK_SEC) begin
                next_st.lock_sec = NBLK'(merge(32'(st.lock_sec), st.wdata, st.wstrb));
            end else if (st.awaddr == fut_pkg::ADDR_MODULE_CFG) begin
                if (st.wstrb[0] && st.wdata[fut_pkg::BIT_RWE]) begin
                    next_st.read_while_write_error = 1'b0;
                end
            end else begin
                next_st.bresp = fut_pkg::RESP_SLVERR;
            end
        end
        // set after the clear so a simultaneous event is kept
        if (i_user_read && !st.done) begin
            next_st.read_while_write_error = 1'b1;
        end

        // ************************************************************
        // AXI4-Lite read channel
        // ************************************************************
        if (st.rvalid && i_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (i_arvalid && !st.rvalid) begin
            next_st.rvalid = 1'b1;
            next_st.rresp  = fut_pkg::RESP_OKAY;
            next_st.rdata  = 32'h0000_0000;
            if (i_araddr == fut_pkg::ADDR_CONTROL) begin
                next_st.rdata = ctrl_view(st);
            end else if (i_araddr >= fut_pkg::ADDR_RESULT0
                         && i_araddr <= fut_pkg::ADDR_RESULT4
                         && i_araddr[1:0] == 2'b00) begin
                ri = 3'(i_araddr[4:2] - 3'h1);
                if (st.done) begin
                    next_st.rdata = st.result[ri];
                end
            end else if (i_araddr == fut_pkg::ADDR_SELECT) begin
                next_st.rdata = 32'(st.sel);
            end else if (i_araddr == fut_pkg::ADDR_LOCK_PRI) begin
                next_st.rdata = 32'(st.lock_pri);
            end else if (i_araddr == fut_pkg::ADDR_LOCK_SEC) begin
                next_st.rdata = 32'(st.lock_sec);
            end else if (i_araddr == fut_pkg::ADDR_MODULE_CFG) begin
                next_st.rdata[fut_pkg::BIT_RWE] = st.read_while_write_error;
            end else begin
                next_st.rresp = fut_pkg::RESP_SLVERR;
            end
        end

        // ************************************************************
        // scan sequencer
        // ************************************************************
        eligible = st.sel[st.blk] && !st.lock_pri[st.blk] && !st.lock_sec[st.blk];
        last     = (st.blk == BW'(NBLK - 1)) && (&st.page);
        case (st.state)
            fut_pkg::FUT_IDLE: begin
                if (launch) begin
                    next_st.done      = 1'b0;
                    next_st.op_margin = st.margin_armed && st.margin_en;
                    next_st.pass      = 3'h0;
                    next_st.blk       = '0;
                    next_st.page      = '0;
                    next_st.wcnt      = wait_count(st.seq, st.margin_armed && st.margin_en);
                    next_st.state     = fut_pkg::FUT_WAIT;
                    misr_load         = 1'b1;
                    misr_seed         = st.result[0];
                end
            end
            fut_pkg::FUT_WAIT: begin
                if (!st.start) begin
                    next_st.done  = 1'b1;
                    next_st.state = fut_pkg::FUT_IDLE;
                end else if (st.wcnt != 8'h00) begin
                    next_st.wcnt = st.wcnt - 8'h01;
                end else if (eligible) begin
                    next_st.array_req  = 1'b1;
                    // main array only: test and shadow blocks lie outside this range
                    next_st.array_addr = {st.blk, st.seq ? st.page : page_rev};
                    next_st.state      = fut_pkg::FUT_READ;
                end else begin
                    next_st.state = fut_pkg::FUT_STEP;
                end
            end
            fut_pkg::FUT_READ: begin
                // an access in flight is allowed to finish before termination
                if (i_array_ack) begin
                    next_st.array_req = 1'b0;
                    misr_shift        = 1'b1;
                    case (st.pass)
                        3'h0:    misr_data = i_array_data[31:0];
                        3'h1:    misr_data = i_array_data[63:32];
                        3'h2:    misr_data = i_array_data[95:64];
                        3'h3:    misr_data = i_array_data[127:96];
                        default: misr_data = {i_array_ecc, 12'h000,
                                              i_array_double_err[1], i_array_single_err[1],
                                              i_array_double_err[0], i_array_single_err[0]};
                    endcase
                    next_st.state = fut_pkg::FUT_STEP;
                end
            end
            fut_pkg::FUT_STEP: begin
                next_st.wcnt  = wait_count(st.seq, st.op_margin);
                next_st.state = fut_pkg::FUT_WAIT;
                if (!st.start) begin
                    next_st.done  = 1'b1;
                    next_st.state = fut_pkg::FUT_IDLE;
                end else if (last) begin
                    next_st.result[st.pass] = misr_sig;
                    next_st.blk  = '0;
                    next_st.page = '0;
                    if (st.pass == fut_pkg::LAST_PASS) begin
                        next_st.done  = 1'b1;
                        next_st.state = fut_pkg::FUT_IDLE;
                    end else begin
                        next_st.pass = st.pass + 3'h1;
                        misr_load    = 1'b1;
                        misr_seed    = st.result[st.pass + 3'h1];
                    end
                end else if (&st.page) begin
                    next_st.page = '0;
                    next_st.blk  = st.blk + BW'(1);
                end else begin
                    next_st.page = st.page + PAGE_AW'(1);
                end
            end
            default: begin
                next_st.state = fut_pkg::FUT_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st       <= '0;
            st.done  <= fut_pkg::CONTROL_RESET[fut_pkg::BIT_DONE];
            st.state <= fut_pkg::FUT_IDLE;
        end else begin
            st <= next_st;
        end
    end

    fut_misr u_misr (
        .i_clk   (i_clk),
        .i_rstn  (i_rstn),
        .i_load  (misr_load),
        .i_seed  (misr_seed),
        .i_shift (misr_shift),
        .i_data  (misr_data),
        .o_sig   (misr_sig)
    );

    // ************************************************************
    // outputs, all from flops
    // ************************************************************
    assign o_awready            = !st.aw_held;
    assign o_wready             = !st.w_held;
    assign o_bvalid             = st.bvalid;
    assign o_bresp              = st.bresp;
    assign o_arready            = !st.rvalid;
    assign o_rvalid             = st.rvalid;
    assign o_rdata              = st.rdata;
    assign o_rresp              = st.rresp;
    assign o_array_req          = st.array_req;
    assign o_array_addr         = st.array_addr;
    assign o_array_margin       = st.op_margin && !st.done;
    assign o_array_margin_level = st.margin_lvl;
    assign o_test_active        = !st.done;
endmodule : fut_engine

// *** bench/fut_engine_props.sv ***
// checker: port properties of the flash user test engine
`timescale 1ns/1ps
module fut_engine_props #(parameter int NBLK = 8, parameter int PAGE_AW = 4) (
    input wire logic                            i_clk,
    input wire logic                            i_rstn,
    input wire logic                            i_bready,
    input wire logic                            i_arvalid,
    input wire logic                            i_array_ack,
    input wire logic                            o_bvalid,
    input wire logic                            o_rvalid,
    input wire logic                            o_arready,
    input wire logic                            o_array_req,
    input wire logic [$clog2(NBLK)+PAGE_AW-1:0] o_array_addr,
    input wire logic                            o_array_margin,
    input wire logic                            o_test_active
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    sequence s_ack; o_array_req && i_array_ack; endsequence
    sequence s_wait; !o_array_req && o_array_margin; endsequence
    property p_req_hold; o_array_req && !i_array_ack |=> o_array_req && $stable(o_array_addr);
    endproperty
    property p_req_drop; s_ack |=> !o_array_req; endproperty
    property p_idle; !o_test_active |-> !o_array_req; endproperty
    property p_margin; $rose(o_array_margin) |-> $rose(o_test_active); endproperty
    // margin accesses need extra settling before each array request
    property p_mwait; s_wait ##1 o_array_req |-> !$past(o_array_req, 7); endproperty
    property p_bdone; o_bvalid && i_bready |=> !o_bvalid; endproperty
    property p_rblock; o_rvalid |-> !o_arready; endproperty
    property p_rcause; $rose(o_rvalid) |-> $past(i_arvalid); endproperty
    a_req_hold: assert property (p_req_hold) else $error("array request lost");
    a_req_drop: assert property (p_req_drop) else $error("array request stuck");
    a_idle: assert property (p_idle) else $error("array access while done");
    a_margin: assert property (p_margin) else $error("margin outside test");
    a_mwait: assert property (p_mwait) else $error("margin wait too short");
    a_bdone: assert property (p_bdone) else $error("write answer repeated");
    a_rblock: assert property (p_rblock) else $error("read taken while busy");
    a_rcause: assert property (p_rcause) else $error("read answer uncaused");
endmodule : fut_engine_props
bind fut_engine fut_engine_props #(.NBLK(NBLK), .PAGE_AW(PAGE_AW)) u_props (.i_clk(i_clk),
    .i_rstn(i_rstn), .i_bready(i_bready), .i_arvalid(i_arvalid), .i_array_ack(i_array_ack),
    .o_bvalid(o_bvalid), .o_rvalid(o_rvalid), .o_arready(o_arready),
    .o_array_req(o_array_req), .o_array_addr(o_array_addr), .o_array_margin(o_array_margin),
    .o_test_active(o_test_active));

// *** bench/flash_user_test_engine_test.sv ***
// testbench: registers, integrity check, abort and margin read
`timescale 1ns/1ps
module flash_user_test_engine_test;
    localparam logic [7:0]   CT = 8'h00;
    localparam logic [127:0] DT = {32'hdead_beef, 32'h0bad_f00d, 32'h1357_9bdf, 32'h2468_ace0};
    logic        i_clk = 0, i_rstn = 0, aw = 0, w = 0, ar = 0, ur = 0, ack = 0;
    logic [7:0]  awa = 8'h00, ara = 8'h00;
    logic [31:0] wd = 32'h0000_0000, d, exp_r[5];
    logic [1:0]  lb, lr;
    wire         awr, wrr, bv, arr, rv, req, mg, ml, act;
    wire [1:0]   br, rr, ad;
    wire [31:0]  rdat;
    int          fail_count = 0, tests_run = 0, cyc = 0;
    fut_engine #(.NBLK(2), .PAGE_AW(1)) u_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_awvalid(aw),
        .o_awready(awr), .i_awaddr(awa), .i_wvalid(w), .o_wready(wrr), .i_wdata(wd),
        .i_wstrb(4'hf), .o_bvalid(bv), .i_bready(1'b1), .o_bresp(br), .i_arvalid(ar),
        .o_arready(arr), .i_araddr(ara), .o_rvalid(rv), .i_rready(1'b1), .o_rdata(rdat),
        .o_rresp(rr), .i_user_read(ur), .o_array_req(req), .o_array_addr(ad),
        .o_array_margin(mg), .o_array_margin_level(ml), .i_array_ack(ack),
        .i_array_data(DT ^ {128{ad[0]}}), .i_array_ecc(16'h5aa5 ^ {16{ad[0]}}),
        .i_array_single_err({ad[0], 1'b1}), .i_array_double_err({1'b0, ad[0]}),
        .o_test_active(act));
    // ************
    // helpers
    // ************
    function automatic logic [31:0] wrd(input int p, input logic g);
        logic [127:0] x;
        x = DT ^ {128{g}};
        return p == 4 ? {16'h5aa5 ^ {16{g}}, 12'h000, 1'b0, g, g, 1'b1} : x[32*p+:32];
    endfunction : wrd
    function automatic logic [31:0] misr(input logic [31:0] s, input logic [31:0] v);
        return {s[30:0], 1'b0} ^ (s[31] ? fut_pkg::MISR_POLY : 32'h0000_0000) ^ v;
    endfunction : misr
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        aw <= 1'b1; w <= 1'b1; awa <= a; wd <= v;
        do begin
            @(posedge i_clk);
            if (awr && aw) aw <= 1'b0;
            if (wrr && w) w <= 1'b0;
        end while (!bv);
        lb = br;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        ar <= 1'b1; ara <= a;
        do @(posedge i_clk); while (!arr);
        ar <= 1'b0;
        do @(posedge i_clk); while (!rv);
        v = rdat;
        lr = rr;
    endtask : rd
    task automatic poll;
        do rd(CT, d); while (d[0] !== 1'b1);
    endtask : poll
    task automatic res_all;
        for (int p = 0; p < 5; p++) begin
            exp_r[p] = misr(misr(exp_r[p], wrd(p, 1'b0)), wrd(p, 1'b1));
            rd(8'h04 + 8'(4 * p), d);
            chk("result", exp_r[p], d);
        end
    endtask : res_all
    task automatic wrap_up;
        if (fail_count == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    // ************
    // scenarios
    // ************
    task automatic t_regs;
        rd(CT, d); chk("ctrl", fut_pkg::CONTROL_RESET, d);
        wr(CT, 32'h8000_0002); rd(CT, d); chk("ctrl", 32'h0000_0001, d);
        wr(CT, fut_pkg::PASSWORD); rd(CT, d); chk("ctrl", 32'h8000_0001, d);
        wr(8'h40, 32'h0000_0000); chk("bresp", 32'(fut_pkg::RESP_SLVERR), 32'(lb));
        rd(8'h40, d); chk("rresp", 32'(fut_pkg::RESP_SLVERR), 32'(lr));
    endtask : t_regs
    task automatic t_check;
        // block 1 selected but locked, so only block 0 feeds the signature
        wr(8'h18, 32'h0000_0003); wr(8'h1c, 32'h0000_0002); wr(8'h20, 32'h0000_0000);
        for (int p = 0; p < 5; p++) begin
            exp_r[p] = 32'(p) * 32'h0101_0101;
            wr(8'h04 + 8'(4 * p), exp_r[p]);
        end
        wr(CT, 32'h8000_0006); rd(8'h04, d); chk("hidden", 32'h0000_0000, d);
        chk("active", 32'h0000_0001, 32'(act));
        ur <= 1'b1; @(posedge i_clk); ur <= 1'b0;
        rd(8'h24, d); chk("rwe", 32'h0000_0001, d & 32'h0000_0001);
        poll; res_all; wr(CT, 32'h8000_0000);
    endtask : t_check
    task automatic t_abort;
        wr(CT, 32'h8000_0002); wr(CT, 32'h8000_0000); poll;
        rd(8'h04, d); chk("aborted", exp_r[0], d);
    endtask : t_abort
    task automatic t_margin;
        wr(CT, 32'h8000_0004); wr(CT, 32'h8000_0024); wr(CT, 32'h8000_0034);
        wr(CT, 32'h8000_0036); chk("margin", 32'h0000_0003, {30'h0, mg, ml});
        poll; res_all; wr(CT, 32'h0000_0000);
    endtask : t_margin
    initial forever #5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        ack <= req && !ack;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            wrap_up;
        end
    end
    initial begin
        repeat (3) @(posedge i_clk);
        i_rstn <= 1'b1;
        @(posedge i_clk);
        t_regs; t_check; t_abort; t_margin;
        wrap_up;
    end
endmodule : flash_user_test_engine_test
